// ===== hw/optical_frontend_pkg.sv
// constants, field layout and state types of the optical front end config registers
// assumes a host that writes whole 24-bit words through a parallel register port
// Functional notes
// R01 - The host keeps every bit of the factory gain register at zero and it drives nothing.
// R02 - Ambient cancel codes 0 to 10 select 0 to 10 uA in 1 uA steps; higher codes are unusable.
// R03 - Bit 14 low bypasses the second receive stage; high enables it at the programmed gain.
// R04 - Second stage gain codes 0 to 4 give gains 1, 1.5, 2, 3 and 4; codes 5 to 7 are unused.
// R05 - Each of the five feedback capacitor bits adds its own capacitor to a fixed base.
// R06 - The three feedback resistor bits pick one of eight settings, code 7 meaning no resistor.
// R07 - LED control bit 17 low keeps the 50 mA current source on, high switches it off.
// R08 - LED control bits 15:8 hold the first LED drive code, reset to zero.
// R09 - LED control bits 7:0 hold the second LED drive code, reset to zero.
// R10 - Each LED current is its code divided by 256 times the 50 mA full scale.
// R11 - Each config register reads back the last value written, reserved bits as written.
`default_nettype none
package optical_frontend_pkg;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 24;
    localparam logic [7:0] FACTORY_GAIN_OFS = 8'h20;
    localparam logic [7:0] RX_CFG_OFS = 8'h21;
    localparam logic [7:0] LED_CFG_OFS = 8'h22;
    localparam logic [23:0] CFG_RESET = 24'h000000;
    localparam int unsigned AMB_LSB = 16;
    localparam int unsigned STG2_EN_BIT = 14;
    localparam int unsigned STG2_GAIN_LSB = 8;
    localparam int unsigned CAP_LSB = 3;
    localparam int unsigned RES_LSB = 0;
    localparam int unsigned LED_OFF_BIT = 17;
    localparam int unsigned FIRST_LED_LSB = 8;
    localparam int unsigned SECOND_LED_LSB = 0;
    localparam logic [3:0] AMB_MAX_CODE = 4'hA;
    localparam logic [2:0] GAIN_MAX_CODE = 3'h4;
    localparam logic [2:0] RES_NONE_CODE = 3'h7;
    localparam logic [3:0] GAIN_X2_UNITY = 4'h2;
    localparam logic [8:0] CAP_BASE_PF = 9'h005;
    localparam logic [8:0] CAP_BIT0_PF = 9'h005;
    localparam logic [8:0] CAP_BIT1_PF = 9'h00F;
    localparam logic [8:0] CAP_BIT2_PF = 9'h019;
    localparam logic [8:0] CAP_BIT3_PF = 9'h032;
    localparam logic [8:0] CAP_BIT4_PF = 9'h096;
    localparam int unsigned LED_FULL_SCALE_UA = 50000;
    localparam int unsigned LED_CODE_DIV = 256;

    typedef struct packed {
        logic [23:0] factory_gain_reserved;
        logic [23:0] receive_gain_ambient_cfg;
        logic [23:0] led_drive_cfg;
        logic [23:0] rdata;
        logic rvalid;
        logic [3:0] amb_ua;
        logic amb_bad;
        logic stg2_en;
        logic [3:0] stg2_gain_x2;
        logic stg2_gain_bad;
        logic [4:0] cap_sw;
        logic [8:0] cap_pf;
        logic [2:0] res_sel;
        logic [6:0] res_onehot;
        logic led_on;
        logic [7:0] first_led;
        logic [7:0] second_led;
        logic [15:0] first_led_ua;
        logic [15:0] second_led_ua;
    } state_s;

    // nominal drive in microamps, truncated
    function automatic logic [15:0] led_ua(input logic [7:0] code);
        logic [31:0] prod;
        prod = 32'(code) * 32'(LED_FULL_SCALE_UA) / 32'(LED_CODE_DIV);
        return prod[15:0];
    endfunction : led_ua
endpackage : optical_frontend_pkg
`default_nettype wire

// ===== hw/optical_frontend_gain_led_regs.sv
// config registers for the receive stage and LED drive, with decoded analog controls
// assumes a host port synchronous to clk_in; decoded outputs lag a write by one cycle
`default_nettype none
module optical_frontend_gain_led_regs
    import optical_frontend_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic reg_wr_en_in,
    input wire logic reg_rd_en_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic [23:0] reg_wdata_in,
    output logic [23:0] reg_rdata_out,
    output logic reg_rvalid_out,
    output logic [3:0] ambient_cancel_current_out,
    output logic ambient_code_bad_out,
    output logic second_stage_enable_out,
    output logic [3:0] second_stage_gain_x2_out,
    output logic second_stage_gain_bad_out,
    output logic [4:0] feedback_cap_select_out,
    output logic [8:0] feedback_cap_pf_out,
    output logic [2:0] feedback_res_select_out,
    output logic [6:0] feedback_res_onehot_out,
    output logic led_source_on_out,
    output logic [7:0] first_led_current_out,
    output logic [7:0] second_led_current_out,
    output logic [15:0] first_led_ua_out,
    output logic [15:0] second_led_ua_out
);
    state_s st_ff;
    state_s nxt_st;

    always_comb begin
        logic [3:0] amb;
        logic [2:0] gain;
        logic [4:0] cap;
        logic [2:0] res;
        nxt_st = st_ff;
        amb = st_ff.receive_gain_ambient_cfg[AMB_LSB +: 4];
        gain = st_ff.receive_gain_ambient_cfg[STG2_GAIN_LSB +: 3];
        cap = st_ff.receive_gain_ambient_cfg[CAP_LSB +: 5];
        res = st_ff.receive_gain_ambient_cfg[RES_LSB +: 3];
        if (reg_wr_en_in) begin
            case (reg_addr_in)
                FACTORY_GAIN_OFS: nxt_st.factory_gain_reserved = reg_wdata_in; // R01
                RX_CFG_OFS: nxt_st.receive_gain_ambient_cfg = reg_wdata_in;
                LED_CFG_OFS: nxt_st.led_drive_cfg = reg_wdata_in;
                default: nxt_st.rdata = st_ff.rdata;
            endcase
        end
        // read returns the pre-write value when both strobes coincide
        nxt_st.rvalid = reg_rd_en_in;
        if (reg_rd_en_in) begin
            case (reg_addr_in)
                FACTORY_GAIN_OFS: nxt_st.rdata = st_ff.factory_gain_reserved; // R11
                RX_CFG_OFS: nxt_st.rdata = st_ff.receive_gain_ambient_cfg; // R11
                LED_CFG_OFS: nxt_st.rdata = st_ff.led_drive_cfg; // R11
                default: nxt_st.rdata = CFG_RESET;
            endcase
        end
        // unusable codes clamp to the top step rather than reach the dac
        nxt_st.amb_bad = (amb > AMB_MAX_CODE); // R02
        nxt_st.amb_ua = (amb > AMB_MAX_CODE) ? AMB_MAX_CODE : amb; // R02
        nxt_st.stg2_en = st_ff.receive_gain_ambient_cfg[STG2_EN_BIT]; // R03
        nxt_st.stg2_gain_bad = nxt_st.stg2_en && (gain > GAIN_MAX_CODE); // R04
        if (!nxt_st.stg2_en) begin
            nxt_st.stg2_gain_x2 = GAIN_X2_UNITY; // R03
        end else begin
            case (gain)
                3'h0: nxt_st.stg2_gain_x2 = 4'h2; // R04
                3'h1: nxt_st.stg2_gain_x2 = 4'h3; // R04
                3'h2: nxt_st.stg2_gain_x2 = 4'h4; // R04
                3'h3: nxt_st.stg2_gain_x2 = 4'h6; // R04
                3'h4: nxt_st.stg2_gain_x2 = 4'h8; // R04
                default: nxt_st.stg2_gain_x2 = GAIN_X2_UNITY;
            endcase
        end
        // switches are independent, so every one of the 32 patterns is legal
        nxt_st.cap_sw = cap; // R05
        nxt_st.cap_pf = CAP_BASE_PF + (cap[0] ? CAP_BIT0_PF : 9'h000) // R05
            + (cap[1] ? CAP_BIT1_PF : 9'h000) + (cap[2] ? CAP_BIT2_PF : 9'h000)
            + (cap[3] ? CAP_BIT3_PF : 9'h000) + (cap[4] ? CAP_BIT4_PF : 9'h000);
        nxt_st.res_sel = res; // R06
        nxt_st.res_onehot = (res == RES_NONE_CODE) ? 7'h00 : 7'(8'h01 << res); // R06
        nxt_st.led_on = !st_ff.led_drive_cfg[LED_OFF_BIT]; // R07
        nxt_st.first_led = st_ff.led_drive_cfg[FIRST_LED_LSB +: 8]; // R08
        nxt_st.second_led = st_ff.led_drive_cfg[SECOND_LED_LSB +: 8]; // R09
        // truncated microamps; the raw code goes out as well for the dac
        nxt_st.first_led_ua = led_ua(nxt_st.first_led); // R10
        nxt_st.second_led_ua = led_ua(nxt_st.second_led); // R10
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            // decoded fields reset to what an all-zero config decodes to
            st_ff <= '0;
            st_ff.stg2_gain_x2 <= GAIN_X2_UNITY;
            st_ff.cap_pf <= CAP_BASE_PF;
            st_ff.res_onehot <= 7'h01;
            st_ff.led_on <= 1'b1;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign reg_rdata_out = st_ff.rdata;
    assign reg_rvalid_out = st_ff.rvalid;
    assign ambient_cancel_current_out = st_ff.amb_ua;
    assign ambient_code_bad_out = st_ff.amb_bad;
    assign second_stage_enable_out = st_ff.stg2_en;
    assign second_stage_gain_x2_out = st_ff.stg2_gain_x2;
    assign second_stage_gain_bad_out = st_ff.stg2_gain_bad;
    assign feedback_cap_select_out = st_ff.cap_sw;
    assign feedback_cap_pf_out = st_ff.cap_pf;
    assign feedback_res_select_out = st_ff.res_sel;
    assign feedback_res_onehot_out = st_ff.res_onehot;
    assign led_source_on_out = st_ff.led_on;
    assign first_led_current_out = st_ff.first_led;
    assign second_led_current_out = st_ff.second_led;
    assign first_led_ua_out = st_ff.first_led_ua;
    assign second_led_ua_out = st_ff.second_led_ua;

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);

    sequence wr_rx_s;
        reg_wr_en_in && reg_addr_in == RX_CFG_OFS;
    endsequence
    sequence wr_led_s;
        reg_wr_en_in && reg_addr_in == LED_CFG_OFS;
    endsequence
    sequence quiet_s;
        !reg_wr_en_in;
    endsequence
    sequence rd_unmapped_s;
        reg_rd_en_in && reg_addr_in != FACTORY_GAIN_OFS && reg_addr_in != RX_CFG_OFS
            && reg_addr_in != LED_CFG_OFS;
    endsequence

    amb_decode_a: assert property (wr_rx_s ##1 quiet_s |=> // R02
        ambient_cancel_current_out == (($past(reg_wdata_in[19:16], 2) > 4'hA) ? 4'hA
            : $past(reg_wdata_in[19:16], 2)))
        else $error("ambient current decode wrong");
    stage_bypass_a: assert property (wr_rx_s ##1 quiet_s |=> // R03
        second_stage_enable_out == $past(reg_wdata_in[14], 2)
        && ($past(reg_wdata_in[14], 2) || second_stage_gain_x2_out == 4'h2))
        else $error("second stage bypass wrong");
    gain_code4_a: assert property ((wr_rx_s and reg_wdata_in[14] // R04
        && reg_wdata_in[10:8] == 3'h4) ##1 quiet_s |=> second_stage_gain_x2_out == 4'h8)
        else $error("gain of four not decoded");
    cap_sum_a: assert property ((wr_rx_s and reg_wdata_in[7:3] == 5'h0F) ##1 quiet_s // R05
        |=> feedback_cap_pf_out == 9'd100)
        else $error("capacitor sum wrong");
    res_none_a: assert property (feedback_res_select_out == 3'h7 // R06
        |-> feedback_res_onehot_out == 7'h00)
        else $error("resistor selected for none code");
    led_source_a: assert property (wr_led_s ##1 quiet_s |=> // R07
        led_source_on_out == !$past(reg_wdata_in[17], 2))
        else $error("led source state wrong");
    led_codes_a: assert property (wr_led_s ##1 quiet_s |=> // R08 R09
        first_led_current_out == $past(reg_wdata_in[15:8], 2)
        && second_led_current_out == $past(reg_wdata_in[7:0], 2))
        else $error("led codes not held");
    led_scale_a: assert property ((wr_led_s and reg_wdata_in[15:8] == 8'hFF) ##1 quiet_s // R10
        |=> first_led_ua_out == 16'd49804)
        else $error("led full scale wrong");
    read_back_a: assert property (wr_rx_s ##1 (reg_rd_en_in && !reg_wr_en_in // R11
        && reg_addr_in == RX_CFG_OFS) |=> reg_rvalid_out
        && reg_rdata_out == $past(reg_wdata_in, 2))
        else $error("read back mismatch");

    // decoded outputs update one edge after the write edge and are sampled at the next, hence the depth of two
    amb_flag_a: assert property (wr_rx_s ##1 quiet_s |=> // R02
        ambient_code_bad_out == ($past(reg_wdata_in[19:16], 2) > 4'hA))
        else $error("ambient code flag wrong");

    gain_flag_a: assert property (wr_rx_s ##1 quiet_s |=> // R04
        second_stage_gain_bad_out == ($past(reg_wdata_in[14], 2)
        && $past(reg_wdata_in[10:8], 2) > 3'h4))
        else $error("second stage gain flag wrong");

    gain_legal_a: assert property ( // R04
        second_stage_gain_x2_out inside {4'h2, 4'h3, 4'h4, 4'h6, 4'h8})
        else $error("second stage gain out of range");

    cap_select_a: assert property (wr_rx_s ##1 quiet_s |=> // R05
        feedback_cap_select_out == $past(reg_wdata_in[7:3], 2))
        else $error("capacitor switches not held");

    cap_total_a: assert property (feedback_cap_pf_out == 9'd5 // R05
        + (feedback_cap_select_out[0] ? 9'd5 : 9'd0)
        + (feedback_cap_select_out[1] ? 9'd15 : 9'd0)
        + (feedback_cap_select_out[2] ? 9'd25 : 9'd0)
        + (feedback_cap_select_out[3] ? 9'd50 : 9'd0)
        + (feedback_cap_select_out[4] ? 9'd150 : 9'd0))
        else $error("capacitor total wrong");

    res_select_a: assert property (wr_rx_s ##1 quiet_s |=> // R06
        feedback_res_select_out == $past(reg_wdata_in[2:0], 2))
        else $error("resistor code not held");

    res_single_a: assert property (feedback_res_select_out != 3'h7 // R06
        |-> $onehot(feedback_res_onehot_out))
        else $error("resistor switches not one hot");

    first_scale_a: assert property (wr_led_s ##1 quiet_s |=> // R10
        32'(first_led_ua_out) == (32'($past(reg_wdata_in[15:8], 2)) * 32'd50000) / 32'd256)
        else $error("first led current scale wrong");

    second_scale_a: assert property (wr_led_s ##1 quiet_s |=> // R10
        32'(second_led_ua_out) == (32'($past(reg_wdata_in[7:0], 2)) * 32'd50000) / 32'd256)
        else $error("second led current scale wrong");

    rvalid_pulse_a: assert property (reg_rvalid_out == $past(reg_rd_en_in)) // R11
        else $error("read valid not a one cycle answer");

    refused_read_a: assert property (rd_unmapped_s |=> reg_rdata_out == 24'h000000) // R11
        else $error("unmapped read not zero");

    // the one check not gated by reset, so it sees the values reset leaves behind
    reset_values_a: assert property (disable iff (1'b0) // R03 R07 R08 R09
        rst_in |=> led_source_on_out && !second_stage_enable_out
        && second_stage_gain_x2_out == 4'h2 && feedback_cap_pf_out == 9'd5
        && first_led_current_out == 8'h00 && second_led_current_out == 8'h00
        && !reg_rvalid_out)
        else $error("reset state wrong");
endmodule : optical_frontend_gain_led_regs
`default_nettype wire

// ===== verif/host_cfg_model.sv
// host model: whole-word register writes and reads
// assumes the device takes strobes on the rising edge of clk_in
`default_nettype none
module host_cfg_model
    import optical_frontend_pkg::*;
(
    input wire logic clk_in,
    output logic wr_en_out,
    output logic rd_en_out,
    output logic [7:0] addr_out,
    output logic [23:0] wdata_out,
    input wire logic [23:0] rdata_in,
    input wire logic rvalid_in
);
    timeunit 1ns;
    timeprecision 1ps;
    initial {wr_en_out, rd_en_out, addr_out, wdata_out} = '0;
    // request held across its rising edge; idle lines go inverted so stale data never matches
    task automatic op(input logic w, input logic [7:0] a, input logic [23:0] dat,
        output logic [24:0] vd);
        @(negedge clk_in);
        wr_en_out = w;
        rd_en_out = !w;
        addr_out = a;
        // factory word stays zero whatever the caller asks
        wdata_out = (a == FACTORY_GAIN_OFS) ? 24'h000000 : dat;
        @(negedge clk_in);
        vd = {rvalid_in, rdata_in};
        {wr_en_out, rd_en_out} = 2'b00;
        addr_out = ~a;
        wdata_out = ~wdata_out;
    endtask : op
    // write then read the same word on back-to-back edges
    task automatic wr_rd(input logic [7:0] a, input logic [23:0] dat,
        output logic [24:0] vd);
        @(negedge clk_in);
        wr_en_out = 1'b1;
        addr_out = a;
        wdata_out = (a == FACTORY_GAIN_OFS) ? 24'h000000 : dat;
        @(negedge clk_in);
        {wr_en_out, rd_en_out} = 2'b01;
        @(negedge clk_in);
        vd = {rvalid_in, rdata_in};
        {wr_en_out, rd_en_out} = 2'b00;
        addr_out = ~a;
        wdata_out = ~wdata_out;
    endtask : wr_rd
endmodule : host_cfg_model
`default_nettype wire

// ===== verif/tb_optical_frontend_gain_led_regs.sv
// bench: corner and random config words, readback and decoded outputs
// assumes host_cfg_model drives the register port on the falling edge
`default_nettype none
module tb_optical_frontend_gain_led_regs
    import optical_frontend_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic we, re, rv, a_bad, s2, g_bad, src_on;
    logic [7:0] ad, l1, l2;
    logic [3:0] amb, gx2;
    logic [4:0] cap;
    logic [8:0] cpf;
    logic [2:0] res;
    logic [6:0] oh;
    logic [15:0] ua1, ua2;
    logic [23:0] wd, rdat, rx, led;
    logic [24:0] vd;
    int error_cnt = 0, compares = 0, seed = 50843;
    // gain x2 with bad flag in bit 0; bad codes fall back to unity
    logic [4:0] g_tab [8] = '{5'h04, 5'h06, 5'h08, 5'h0C, 5'h10, 5'h05, 5'h05, 5'h05};
    logic [23:0] rx_tab [5] = '{24'h000000, 24'h0A447F, 24'h0B4586, 24'h000300, 24'h0F07FF};
    logic [23:0] led_tab [5] = '{24'h000000, 24'h01FF00, 24'h0300FF, 24'h01FFFF, 24'h030000};
    host_cfg_model host (.clk_in(clk_in), .wr_en_out(we), .rd_en_out(re), .addr_out(ad),
        .wdata_out(wd), .rdata_in(rdat), .rvalid_in(rv));
    optical_frontend_gain_led_regs uut (.clk_in(clk_in), .rst_in(rst_in), .reg_wr_en_in(we),
        .reg_rd_en_in(re), .reg_addr_in(ad), .reg_wdata_in(wd), .reg_rdata_out(rdat),
        .reg_rvalid_out(rv), .ambient_cancel_current_out(amb), .ambient_code_bad_out(a_bad),
        .second_stage_enable_out(s2), .second_stage_gain_x2_out(gx2),
        .second_stage_gain_bad_out(g_bad), .feedback_cap_select_out(cap),
        .feedback_cap_pf_out(cpf), .feedback_res_select_out(res),
        .feedback_res_onehot_out(oh), .led_source_on_out(src_on), .first_led_current_out(l1),
        .second_led_current_out(l2), .first_led_ua_out(ua1), .second_led_ua_out(ua2));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic complete_run();
        $display("errors=%0d compares=%0d", error_cnt, compares);
        if (error_cnt == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : complete_run
    initial forever #5 clk_in = ~clk_in;
    initial begin
        #50000;
        error_cnt++;
        complete_run();
    end
    // pass 0 checks reset values, later passes write first
    initial begin
        repeat (16) @(negedge clk_in);
        rst_in = 1'b0;
        for (int i = 0; i < 40; i++) begin
            rx = (i < 5) ? rx_tab[i] : 24'($random(seed)) & 24'h0F47FF;
            led = (i < 5) ? led_tab[i] : (24'($random(seed)) & 24'h02FFFF) | 24'h010000;
            if (i > 0) begin
                host.wr_rd(RX_CFG_OFS, rx, vd);
                chk(vd, {1'b1, rx});
                host.op(1'b1, FACTORY_GAIN_OFS, rx, vd);
                host.op(1'b1, 8'h23, rx, vd);
                host.op(1'b1, LED_CFG_OFS, led, vd);
            end
            host.op(1'b0, RX_CFG_OFS, rx, vd);
            chk(vd, {1'b1, rx});
            host.op(1'b0, LED_CFG_OFS, led, vd);
            chk(vd, {1'b1, led});
            chk({amb, a_bad}, {(rx[19:16] > 4'hA) ? 4'hA : rx[19:16], rx[19:16] > 4'hA});
            chk({s2, gx2, g_bad}, {rx[14], rx[14] ? g_tab[rx[10:8]] : 5'h04});
            chk({cap, cpf}, {rx[7:3], 9'h005 + 9'(rx[3]) * 9'h005 + 9'(rx[4]) * 9'h00F
                + 9'(rx[5]) * 9'h019 + 9'(rx[6]) * 9'h032 + 9'(rx[7]) * 9'h096});
            chk({res, oh}, {rx[2:0], (rx[2:0] == 3'h7) ? 7'h00 : 7'h01 << rx[2:0]});
            chk({src_on, l1, l2}, {~led[17], led[15:0]});
            chk(ua1, 32'(led[15:8]) * 32'h0000C350 / 32'h00000100);
            chk(ua2, 32'(led[7:0]) * 32'h0000C350 / 32'h00000100);
            host.op(1'b0, FACTORY_GAIN_OFS, rx, vd);
            chk(vd, 32'h01000000);
            host.op(1'b0, 8'h23, rx, vd);
            chk(vd, 32'h01000000);
        end
        complete_run();
    end
endmodule : tb_optical_frontend_gain_led_regs
`default_nettype wire
